// [src/vsb_pkg.sv]
// Purpose: shared constants for the oscillator subsystem config bank
// Assumes: one clock, 17-bit forwarded write words
// Notes: used by both ends of the forwarding link
package vsb_pkg;
   localparam int WORD_W = 17;
   localparam int DATA_W = 9;
   // forwarded word layout
   localparam int ID_LSB = 0;
   localparam int ID_MSB = 2;
   localparam int ADDR_LSB = 3;
   localparam int ADDR_MSB = 6;
   localparam int DATA_LSB = 7;
   localparam int DATA_MSB = 15;
   localparam logic [2:0] SUBSYS_ID = 3'h0;
   // bank register addresses
   localparam logic [3:0] ADDR_DIV_GAIN = 4'h2;
   localparam logic [3:0] ADDR_PATH_CFG = 4'h3;
   localparam logic [3:0] ADDR_CAL_BIAS = 4'h4;
   localparam logic [3:0] ADDR_COARSE = 4'h5;
   localparam logic [3:0] ADDR_UPPER = 4'h6;
   // reset values
   localparam logic [8:0] RST_DIV_GAIN = 9'h0C1;
   localparam logic [8:0] RST_PATH_CFG = 9'h051;
   localparam logic [8:0] RST_CAL_BIAS = 9'h0C9;
   localparam logic [8:0] RST_COARSE = 9'h0AA;
   localparam logic [8:0] RST_UPPER = 9'h0FF;
   // values the writer must load
   localparam logic [8:0] REQ_CAL_BIAS = 9'h0C1;
   localparam logic [8:0] REQ_COARSE = 9'h02C;
   localparam logic [8:0] REQ_UPPER = 9'h0FF;
   localparam logic [1:0] BIAS_FUND = 2'h2;
   localparam logic [1:0] BIAS_DBL = 2'h0;
   localparam logic [3:0] PATH_SPARE = 4'h2;
   localparam logic [5:0] MAX_RATIO = 6'h3E;
   localparam logic [5:0] FLAT_GAIN_RATIO = 6'h04;
   // controller register byte offsets
   localparam logic [3:0] OFS_RAW = 4'h0;
   localparam logic [3:0] OFS_SETUP = 4'h4;
   localparam logic [3:0] OFS_CAL = 4'h8;
   localparam logic [3:0] OFS_STATUS = 4'hC;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [5:0] PEND_NONE = 6'h00;
endpackage

// [src/vsb_link_if.sv]
// Purpose: forwarding link between PLL register logic and config bank
// Assumes: shared aclk, word taken when valid and ready are both high
// Notes: no clocking block
`timescale 1ns/1ns
`default_nettype none
interface vsb_link_if;
   logic fwd_valid;
   logic fwd_ready;
   logic [16:0] fwd_word;
   modport dev (input fwd_valid, input fwd_word, output fwd_ready);
   modport pll (output fwd_valid, output fwd_word, input fwd_ready);
endinterface
`default_nettype wire

// [src/vsb_config_bank.sv]
// Purpose: oscillator subsystem write-only configuration bank
// Assumes: forwarded words arrive from PLL register logic on aclk
// Notes:
// Contract
// - buffer gain bits 7:6, reset 3
// - divider stage gain bit 8, reset 0
// - writer sets divider gain per ratio
// - word: id 2:0, addr 6:3, data above
// - config bit 0 fundamental, reset 1
// - config bit 2 selects manual enables
// - writer sets buffer bias per band
// - writer loads fixed calibration bias values
// - writer loads fixed coarse calibration values
// - ratio 0 mutes in automatic mode, even ratios divide
// - bank reached only through forwarding register
`timescale 1ns/1ns
`default_nettype none
module vsb_config_bank
   import vsb_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   vsb_link_if.dev link,
   input wire logic master_enable,
   input wire logic [3:0] manual_enables,
   output logic [1:0] buffer_gain,
   output logic divider_gain_max,
   output logic fundamental_mode,
   output logic manual_output_enable_mode,
   output logic [1:0] buffer_bias,
   output logic [2:0] osc_bias,
   output logic [1:0] pll_buffer_bias,
   output logic [1:0] limiter_bias,
   output logic [1:0] preset_cal,
   output logic [1:0] coarse_cal_low,
   output logic [1:0] coarse_cal_mid_low,
   output logic [1:0] coarse_cal_mid_high,
   output logic [1:0] coarse_cal_high,
   output logic [1:0] upper_cal_low,
   output logic [1:0] upper_cal_mid_low,
   output logic [1:0] upper_cal_mid_high,
   output logic [1:0] upper_cal_high,
   output logic [5:0] divide_ratio,
   output logic output_muted,
   output logic pll_buffer_en,
   output logic rf_buffer_en,
   output logic div1_en,
   output logic rf_divider_en,
   output logic word_ignored
);
   logic [8:0] div_gain_ff;
   logic [8:0] path_cfg_ff;
   logic [8:0] cal_bias_ff;
   logic [8:0] coarse_ff;
   logic [8:0] upper_ff;
   logic [5:0] ratio_ff;
   logic mute_ff;
   logic pll_buf_ff;
   logic rf_buf_ff;
   logic div1_ff;
   logic rf_div_ff;
   logic ignored_ff;
   logic [5:0] nxt_ratio;
   logic nxt_pll_buf;
   logic nxt_rf_buf;
   logic nxt_div1;
   logic nxt_rf_div;

   // word decode
   wire take = link.fwd_valid & link.fwd_ready;
   wire [2:0] word_id = link.fwd_word[ID_MSB:ID_LSB];
   wire [3:0] word_addr = link.fwd_word[ADDR_MSB:ADDR_LSB];
   wire [8:0] word_data = link.fwd_word[DATA_MSB:DATA_LSB];
   wire id_hit = (word_id == SUBSYS_ID);
   wire wr_div_gain = take & id_hit & (word_addr == ADDR_DIV_GAIN);
   wire wr_path_cfg = take & id_hit & (word_addr == ADDR_PATH_CFG);
   wire wr_cal_bias = take & id_hit & (word_addr == ADDR_CAL_BIAS);
   wire wr_coarse = take & id_hit & (word_addr == ADDR_COARSE);
   wire wr_upper = take & id_hit & (word_addr == ADDR_UPPER);
   wire any_hit = wr_div_gain | wr_path_cfg | wr_cal_bias | wr_coarse
      | wr_upper;

   // bank always accepts; single entry point from PLL side
   assign link.fwd_ready = 1'b1;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_gain_ff <= RST_DIV_GAIN;
         path_cfg_ff <= RST_PATH_CFG;
         cal_bias_ff <= RST_CAL_BIAS;
         coarse_ff <= RST_COARSE;
         upper_ff <= RST_UPPER;
      end else begin
         if (wr_div_gain) begin
            div_gain_ff <= word_data;
         end
         if (wr_path_cfg) begin
            path_cfg_ff <= word_data;
         end
         if (wr_cal_bias) begin
            cal_bias_ff <= word_data;
         end
         if (wr_coarse) begin
            coarse_ff <= word_data;
         end
         if (wr_upper) begin
            upper_ff <= word_data;
         end
      end
   end

   // field outputs straight from the bank flops
   assign buffer_gain = div_gain_ff[7:6];
   assign divider_gain_max = div_gain_ff[8];
   assign fundamental_mode = path_cfg_ff[0];
   assign manual_output_enable_mode = path_cfg_ff[2];
   assign buffer_bias = path_cfg_ff[4:3];
   assign osc_bias = cal_bias_ff[2:0];
   assign pll_buffer_bias = cal_bias_ff[4:3];
   assign limiter_bias = cal_bias_ff[6:5];
   assign preset_cal = cal_bias_ff[8:7];
   assign coarse_cal_low = coarse_ff[1:0];
   assign coarse_cal_mid_low = coarse_ff[3:2];
   assign coarse_cal_mid_high = coarse_ff[5:4];
   assign coarse_cal_high = coarse_ff[7:6];
   assign upper_cal_low = upper_ff[1:0];
   assign upper_cal_mid_low = upper_ff[3:2];
   assign upper_cal_mid_high = upper_ff[5:4];
   assign upper_cal_high = upper_ff[7:6];

   // effective divide ratio: odd codes above 1 drop to the even below
   wire [5:0] raw_ratio = div_gain_ff[5:0];
   wire ratio_big = (raw_ratio > MAX_RATIO);
   wire ratio_one = (raw_ratio == 6'h01);
   wire ratio_zero = (raw_ratio == 6'h00);
   wire [5:0] even_ratio = {raw_ratio[5:1], 1'b0};

   always_comb begin
      if (ratio_big) begin
         nxt_ratio = MAX_RATIO;
      end else if (ratio_one) begin
         nxt_ratio = raw_ratio;
      end else begin
         nxt_ratio = even_ratio;
      end
   end

   // enables: automatic from ratio, manual from enables input
   wire auto_mode = ~path_cfg_ff[2];
   wire man_pll_buf = manual_enables[0];
   wire man_rf_buf = manual_enables[1];
   wire man_div1 = manual_enables[2];
   wire man_rf_div = manual_enables[3];

   always_comb begin
      nxt_pll_buf = 1'b0;
      nxt_rf_buf = 1'b0;
      nxt_div1 = 1'b0;
      nxt_rf_div = 1'b0;
      if (master_enable) begin
         if (auto_mode) begin
            nxt_pll_buf = 1'b1;
            nxt_rf_buf = ~ratio_zero;
            nxt_div1 = ratio_one;
            nxt_rf_div = ~ratio_zero & ~ratio_one;
         end else begin
            nxt_pll_buf = man_pll_buf;
            nxt_rf_buf = man_rf_buf;
            nxt_div1 = man_div1;
            nxt_rf_div = man_rf_div;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ratio_ff <= 6'h01;
         mute_ff <= 1'b0;
         pll_buf_ff <= 1'b0;
         rf_buf_ff <= 1'b0;
         div1_ff <= 1'b0;
         rf_div_ff <= 1'b0;
         ignored_ff <= 1'b0;
      end else begin
         ratio_ff <= nxt_ratio;
         mute_ff <= auto_mode & ratio_zero;
         pll_buf_ff <= nxt_pll_buf;
         rf_buf_ff <= nxt_rf_buf;
         div1_ff <= nxt_div1;
         rf_div_ff <= nxt_rf_div;
         ignored_ff <= take & ~any_hit;
      end
   end

   assign divide_ratio = ratio_ff;
   assign output_muted = mute_ff;
   assign pll_buffer_en = pll_buf_ff;
   assign rf_buffer_en = rf_buf_ff;
   assign div1_en = div1_ff;
   assign rf_divider_en = rf_div_ff;
   assign word_ignored = ignored_ff;
endmodule // vsb_config_bank
`default_nettype wire

// [src/vsb_pll_writer.sv]
// Purpose: PLL-side forwarding logic driven over AXI4-Lite
// Assumes: one write and one read at a time from the bus master
// Notes: writes while busy are refused with SLVERR
`timescale 1ns/1ns
`default_nettype none
module vsb_pll_writer
   import vsb_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   vsb_link_if.pll link
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_SEND = 2'b10
   } vsb_state_type;

   vsb_state_type state_ff;
   vsb_state_type nxt_state;
   logic aw_ff;
   logic w_ff;
   logic [3:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [16:0] raw_ff;
   logic [9:0] setup_ff;
   logic [5:0] pend_ff;
   logic [5:0] nxt_pend;
   logic [16:0] word_ff;
   logic [16:0] nxt_word;
   logic [7:0] sent_ff;

   wire busy = (pend_ff != PEND_NONE) | (state_ff == ST_SEND);
   wire do_wr = aw_ff & w_ff & ~bvalid_ff;
   wire wr_ok = do_wr & ~busy;
   wire full_strb = (wstrb_ff == 4'hF);
   wire hit_raw = (awaddr_ff == OFS_RAW);
   wire hit_setup = (awaddr_ff == OFS_SETUP);
   wire hit_cal = (awaddr_ff == OFS_CAL);
   wire mapped = hit_raw | hit_setup | hit_cal;
   wire rd_take = s_axi_arvalid & ~rvalid_ff;

   // words built from the setup register and the fixed load values
   wire [5:0] su_ratio = setup_ff[5:0];
   wire [1:0] su_gain = setup_ff[7:6];
   wire su_doubler = setup_ff[8];
   wire su_manual = setup_ff[9];
   wire div_gain_bit = (su_ratio < FLAT_GAIN_RATIO);
   wire [1:0] bias_sel = su_doubler ? BIAS_DBL : BIAS_FUND;
   wire [8:0] d_div = {div_gain_bit, su_gain, su_ratio};
   wire [8:0] d_cfg = {PATH_SPARE, bias_sel, su_manual, 1'b0,
      ~su_doubler};
   wire [16:0] w_div = {1'b0, d_div, ADDR_DIV_GAIN, SUBSYS_ID};
   wire [16:0] w_cfg = {1'b0, d_cfg, ADDR_PATH_CFG, SUBSYS_ID};
   wire [16:0] w_cal = {1'b0, REQ_CAL_BIAS, ADDR_CAL_BIAS,
      SUBSYS_ID};
   wire [16:0] w_crs = {1'b0, REQ_COARSE, ADDR_COARSE, SUBSYS_ID};
   wire [16:0] w_up = {1'b0, REQ_UPPER, ADDR_UPPER, SUBSYS_ID};
   wire [31:0] status_word = {16'h0000, sent_ff, 7'h00, busy};

   assign s_axi_awready = ~aw_ff & ~bvalid_ff;
   assign s_axi_wready = ~w_ff & ~bvalid_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = ~rvalid_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = RESP_OKAY;
   assign link.fwd_valid = (state_ff == ST_SEND);
   assign link.fwd_word = word_ff;

   // pick lowest pending word: raw, div, cfg, cal, coarse, upper
   always_comb begin
      nxt_state = state_ff;
      nxt_pend = pend_ff;
      nxt_word = word_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (pend_ff[0]) begin
               nxt_word = raw_ff;
               nxt_pend[0] = 1'b0;
            end else if (pend_ff[1]) begin
               nxt_word = w_div;
               nxt_pend[1] = 1'b0;
            end else if (pend_ff[2]) begin
               nxt_word = w_cfg;
               nxt_pend[2] = 1'b0;
            end else if (pend_ff[3]) begin
               nxt_word = w_cal;
               nxt_pend[3] = 1'b0;
            end else if (pend_ff[4]) begin
               nxt_word = w_crs;
               nxt_pend[4] = 1'b0;
            end else if (pend_ff[5]) begin
               nxt_word = w_up;
               nxt_pend[5] = 1'b0;
            end
            if (pend_ff != PEND_NONE) begin
               nxt_state = ST_SEND;
            end
         end
         ST_SEND: begin
            if (link.fwd_ready) begin
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
      if (wr_ok & full_strb) begin
         nxt_pend = {hit_cal, hit_cal, hit_cal, hit_setup, hit_setup,
            hit_raw};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_ff <= 1'b0;
         w_ff <= 1'b0;
         awaddr_ff <= 4'h0;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end else if (do_wr) begin
            aw_ff <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end else if (do_wr) begin
            w_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end else if (do_wr) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= (busy | ~mapped) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         raw_ff <= 17'h0_0000;
         setup_ff <= 10'h0C1;
      end else if (wr_ok & full_strb & hit_raw) begin
         raw_ff <= wdata_ff[16:0];
      end else if (wr_ok & full_strb & hit_setup) begin
         setup_ff <= wdata_ff[9:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
      end else if (rd_take) begin
         rvalid_ff <= 1'b1;
         rdata_ff <= (s_axi_araddr == OFS_STATUS) ? status_word
            : 32'h0000_0000;
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= ST_IDLE;
         pend_ff <= PEND_NONE;
         word_ff <= 17'h0_0000;
         sent_ff <= 8'h00;
      end else begin
         state_ff <= nxt_state;
         pend_ff <= nxt_pend;
         word_ff <= nxt_word;
         if (link.fwd_valid & link.fwd_ready) begin
            sent_ff <= sent_ff + 8'h01;
         end
      end
   end
endmodule // vsb_pll_writer
`default_nettype wire

// [verification/vsb_link_properties.sv]
// Purpose: link and bank output checks for the forwarding path
// Assumes: shared aclk, synchronous active-low aresetn
// Notes: instantiated beside the link interface, no bind
`timescale 1ns/1ns
`default_nettype none
module vsb_link_properties
   import vsb_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic fwd_valid,
   input wire logic fwd_ready,
   input wire logic [16:0] fwd_word,
   input wire logic [1:0] buffer_gain,
   input wire logic divider_gain_max,
   input wire logic fundamental_mode,
   input wire logic manual_output_enable_mode,
   input wire logic [1:0] buffer_bias,
   input wire logic word_ignored
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   logic hit_id;
   logic hit_02;
   logic hit_03;
   logic bad;
   logic [8:0] data_ff;
   assign hit_id = fwd_valid && fwd_ready && fwd_word[2:0] == SUBSYS_ID;
   assign hit_02 = hit_id && fwd_word[6:3] == ADDR_DIV_GAIN;
   assign hit_03 = hit_id && fwd_word[6:3] == ADDR_PATH_CFG;
   assign bad = fwd_valid && fwd_ready && (fwd_word[2:0] != SUBSYS_ID
      || fwd_word[6:3] < ADDR_DIV_GAIN || fwd_word[6:3] > ADDR_UPPER);
   // data field of the word taken last cycle
   always_ff @(posedge aclk) begin
      data_ff <= fwd_word[DATA_MSB:DATA_LSB];
   end
   AST_READY_HIGH: assert property (fwd_ready)
      else $error("link ready low");
   AST_VALID_PULSE: assert property (fwd_valid |=> !fwd_valid)
      else $error("word offered two cycles");
   AST_GAIN_LOAD: assert property (hit_02 |=>
      buffer_gain == data_ff[7:6])
      else $error("buffer gain not loaded");
   AST_DIVGAIN_LOAD: assert property (hit_02 |=>
      divider_gain_max == data_ff[8])
      else $error("divider gain not loaded");
   AST_FUND_LOAD: assert property (hit_03 |=>
      fundamental_mode == data_ff[0])
      else $error("mode select not loaded");
   AST_MANUAL_LOAD: assert property (hit_03 |=>
      manual_output_enable_mode == data_ff[2])
      else $error("manual mode not loaded");
   AST_BIAS_LOAD: assert property (hit_03 |=>
      buffer_bias == data_ff[4:3])
      else $error("buffer bias not loaded");
   AST_IGNORE_FLAG: assert property (bad |=> word_ignored)
      else $error("bad word not flagged");
   AST_IGNORE_KEEP: assert property (bad |=> $stable(buffer_gain)
      && $stable(fundamental_mode) && $stable(buffer_bias))
      else $error("bad word changed a register");
   AST_FLAG_CAUSE: assert property (word_ignored |-> $past(bad))
      else $error("flag without bad word");
   cover property (hit_02);
   cover property (bad ##1 word_ignored);
   cover property (fwd_valid ##2 fwd_valid);
endmodule // vsb_link_properties
`default_nettype wire

// [verification/vsb_config_bank_tb_top.sv]
// Purpose: end-to-end bench for the writer and config bank
// Assumes: 125 MHz aclk, AXI4-Lite master driven at rising edges
// Notes: setup table first, then reset, cal, raw and refusal cases
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) \
   begin \
      compares++; \
      if ((gt) !== (ex)) begin \
         err_count++; \
         $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); \
      end \
   end
module vsb_config_bank_tb_top
   import vsb_pkg::*;
;
   typedef struct packed {
      logic [9:0] setup;
      logic [1:0] gain;
      logic dgain;
      logic fund;
      logic man;
      logic [1:0] bias;
      logic [5:0] ratio;
      logic muted;
      logic pll_en;
      logic rf_en;
   } vsb_row_type;
   vsb_row_type rows [6] = '{
      '{10'h0FE, 2'h3, 1'b0, 1'b1, 1'b0, 2'h2, 6'h3E, 1'b0, 1'b1, 1'b1},
      '{10'h281, 2'h2, 1'b1, 1'b1, 1'b1, 2'h2, 6'h01, 1'b0, 1'b0, 1'b1},
      '{10'h045, 2'h1, 1'b0, 1'b1, 1'b0, 2'h2, 6'h04, 1'b0, 1'b1, 1'b1},
      '{10'h1FF, 2'h3, 1'b0, 1'b0, 1'b0, 2'h0, 6'h3E, 1'b0, 1'b1, 1'b1},
      '{10'h0C3, 2'h3, 1'b1, 1'b1, 1'b0, 2'h2, 6'h02, 1'b0, 1'b1, 1'b1},
      '{10'h100, 2'h0, 1'b1, 1'b0, 1'b0, 2'h0, 6'h00, 1'b1, 1'b1, 1'b0}
   };
   logic [16:0] raw_bad [3] = '{17'h00011, 17'h00000, 17'h00038};
   int err_count = 0;
   int compares = 0;
   int ign_count = 0;
   int ign0;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [3:0] s_axi_awaddr = 4'h0;
   logic [3:0] s_axi_araddr = 4'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic master_enable = 1'b1;
   logic [3:0] manual_enables = 4'hA;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [1:0] s_axi_bresp, resp, resp2;
   logic [31:0] s_axi_rdata, st0, st1;
   logic [1:0] buffer_gain, buffer_bias, pll_buffer_bias, limiter_bias;
   logic [1:0] preset_cal, coarse_cal_low, coarse_cal_mid_low;
   logic [1:0] coarse_cal_mid_high, coarse_cal_high, upper_cal_low;
   logic [1:0] upper_cal_mid_low, upper_cal_mid_high, upper_cal_high;
   logic [2:0] osc_bias;
   logic [5:0] divide_ratio;
   logic divider_gain_max, fundamental_mode, manual_output_enable_mode;
   logic output_muted, pll_buffer_en, rf_buffer_en, word_ignored;
   logic div1_en, rf_divider_en;
   vsb_link_if link ();
   vsb_pll_writer i_vsb_pll_writer (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp(), .s_axi_rvalid, .s_axi_rready,
      .link(link));
   vsb_config_bank i_vsb_config_bank (.aclk, .aresetn, .link(link),
      .master_enable, .manual_enables, .buffer_gain, .divider_gain_max,
      .fundamental_mode, .manual_output_enable_mode, .buffer_bias,
      .osc_bias, .pll_buffer_bias, .limiter_bias, .preset_cal,
      .coarse_cal_low, .coarse_cal_mid_low, .coarse_cal_mid_high,
      .coarse_cal_high, .upper_cal_low, .upper_cal_mid_low,
      .upper_cal_mid_high, .upper_cal_high, .divide_ratio, .output_muted,
      .pll_buffer_en, .rf_buffer_en, .div1_en, .rf_divider_en,
      .word_ignored);
   vsb_link_properties i_vsb_link_properties (.aclk, .aresetn,
      .fwd_valid(link.fwd_valid), .fwd_ready(link.fwd_ready),
      .fwd_word(link.fwd_word), .buffer_gain, .divider_gain_max,
      .fundamental_mode, .manual_output_enable_mode, .buffer_bias,
      .word_ignored);
   initial begin
      forever #4 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      if (word_ignored === 1'b1) ign_count++;
   end
   task automatic final_report();
      $display("compares %0d errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // write: hold each channel until its own handshake
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
         output logic [1:0] r);
      logic aw_hit, w_hit, b_hit;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      b_hit = 1'b0;
      while (!b_hit) begin
         @(negedge aclk);
         aw_hit = s_axi_awvalid && s_axi_awready;
         w_hit = s_axi_wvalid && s_axi_wready;
         b_hit = s_axi_bvalid && s_axi_bready;
         r = s_axi_bresp;
         @(posedge aclk);
         if (aw_hit) s_axi_awvalid <= 1'b0;
         if (w_hit) s_axi_wvalid <= 1'b0;
         if (b_hit) s_axi_bready <= 1'b0;
      end
   endtask
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
      logic ar_hit, r_hit;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      r_hit = 1'b0;
      while (!r_hit) begin
         @(negedge aclk);
         ar_hit = s_axi_arvalid && s_axi_arready;
         r_hit = s_axi_rvalid && s_axi_rready;
         d = s_axi_rdata;
         @(posedge aclk);
         if (ar_hit) s_axi_arvalid <= 1'b0;
         if (r_hit) s_axi_rready <= 1'b0;
      end
   endtask
   // poll busy, then let the derived enables settle
   task automatic wait_idle();
      logic [31:0] st;
      st = 32'h1;
      for (int i = 0; i < 40 && st[0] !== 1'b0; i++) axi_rd(OFS_STATUS, st);
      `CHK("busy", 1'b0, st[0])
      repeat (3) @(posedge aclk);
      @(negedge aclk);
   endtask
   initial begin
      #200000;
      err_count++;
      final_report();
   end
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rows[k]) begin
         axi_wr(OFS_SETUP, {22'h0, rows[k].setup}, resp);
         `CHK("setup_resp", RESP_OKAY, resp)
         wait_idle();
         `CHK("buffer_gain", rows[k].gain, buffer_gain)
         `CHK("div_gain", rows[k].dgain, divider_gain_max)
         `CHK("fundamental", rows[k].fund, fundamental_mode)
         `CHK("manual", rows[k].man, manual_output_enable_mode)
         `CHK("buffer_bias", rows[k].bias, buffer_bias)
         `CHK("ratio", rows[k].ratio, divide_ratio)
         `CHK("muted", rows[k].muted, output_muted)
         `CHK("pll_en", rows[k].pll_en, pll_buffer_en)
         `CHK("rf_en", rows[k].rf_en, rf_buffer_en)
         `CHK("rf_div", rows[k].rf_en, rf_divider_en)
         `CHK("div1", 1'b0, div1_en)
      end
      // second reset in mid-run
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (20) @(posedge aclk);
      @(negedge aclk);
      `CHK("rst_gain", 2'h3, buffer_gain)
      `CHK("rst_div_gain", 1'b0, divider_gain_max)
      `CHK("rst_fund", 1'b1, fundamental_mode)
      `CHK("rst_manual", 1'b0, manual_output_enable_mode)
      `CHK("rst_ratio", 6'h01, divide_ratio)
      `CHK("rst_coarse", 8'hAA, {coarse_cal_high, coarse_cal_mid_high,
         coarse_cal_mid_low, coarse_cal_low})
      @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(OFS_STATUS, st0);
      @(negedge aclk);
      `CHK("rel_div1", 1'b1, div1_en)
      `CHK("rel_rf_div", 1'b0, rf_divider_en)
      axi_wr(OFS_CAL, 32'h0, resp);
      axi_wr(OFS_CAL, 32'h0, resp2);
      `CHK("cal_resp", RESP_OKAY, resp)
      `CHK("busy_resp", RESP_SLVERR, resp2)
      wait_idle();
      axi_rd(OFS_STATUS, st1);
      `CHK("sent_count", st0[15:8] + 8'h3, st1[15:8])
      `CHK("cal_bias", 9'h0C1, {preset_cal, limiter_bias, pll_buffer_bias,
         osc_bias})
      `CHK("coarse", 8'h2C, {coarse_cal_high, coarse_cal_mid_high,
         coarse_cal_mid_low, coarse_cal_low})
      `CHK("upper", 8'hFF, {upper_cal_high, upper_cal_mid_high,
         upper_cal_mid_low, upper_cal_low})
      ign0 = ign_count;
      foreach (raw_bad[k]) begin
         axi_wr(OFS_RAW, {15'h0, raw_bad[k]}, resp);
         wait_idle();
      end
      `CHK("ignored", ign0 + 3, ign_count)
      `CHK("ign_gain", 2'h3, buffer_gain)
      axi_wr(OFS_RAW, {15'h0, 17'h0BF10}, resp);
      wait_idle();
      `CHK("raw_gain", 2'h1, buffer_gain)
      `CHK("raw_div_gain", 1'b1, divider_gain_max)
      `CHK("raw_fund", 1'b1, fundamental_mode)
      `CHK("raw_coarse", 8'h2C, {coarse_cal_high, coarse_cal_mid_high,
         coarse_cal_mid_low, coarse_cal_low})
      axi_wr(OFS_STATUS, 32'h0, resp);
      `CHK("unmapped_resp", RESP_SLVERR, resp)
      axi_rd(OFS_SETUP, st0);
      `CHK("wo_read", 32'h0, st0)
      s_axi_wstrb <= 4'h3;
      axi_wr(OFS_CAL, 32'h0, resp);
      s_axi_wstrb <= 4'hF;
      `CHK("strb_resp", RESP_OKAY, resp)
      axi_rd(OFS_STATUS, st1);
      `CHK("strb_busy", 1'b0, st1[0])
      master_enable <= 1'b0;
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      `CHK("off_pll_en", 1'b0, pll_buffer_en)
      `CHK("off_rf_en", 1'b0, rf_buffer_en)
      final_report();
   end
endmodule // vsb_config_bank_tb_top
`default_nettype wire
